// >>> tb/instruction_stream_coherence_bench.sv
`timescale 1ns/1ps
`default_nettype none
module instruction_stream_coherence_bench;
  logic                  clock, arst_n, stall, rel;
  isc_pkg::isc_op_t      op;
  logic                  op_ready, op_done, misalign, mem_ready, fence_idle;
  isc_pkg::isc_mem_req_t mem_req;
  isc_pkg::isc_mem_ack_t mem_ack;
  isc_pkg::isc_fetch_t   fetch_ctl;
  int                    errors, total_checks;
  isc_core DUT (.clock, .arst_n, .op, .op_ready, .op_done, .misalign,
    .mem_req, .mem_ready, .mem_ack, .fetch_ctl, .fence_idle);
  isc_mem_model u_mem (.clock, .arst_n, .stall, .mem_req, .mem_ready,
    .mem_ack);
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [63:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check
  // returns at the falling edge of the done cycle
  task automatic do_op(input isc_pkg::isc_kind_t k, input logic [63:0] a,
                       input logic [1:0] sz, input logic dep);
    int n;
    n = 0;
    @(negedge clock);
    while (!op_ready) @(negedge clock);
    op = '{1'h1, k, a, 64'h0123_4567_89AB_CDEF, sz, dep};
    @(negedge clock);
    op.valid = 1'h0;
    while (op_done !== 1'h1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    check(op_done, 1'h1, "no done");
  endtask : do_op
  // op must not finish before the stalled memory is let go
  task automatic hold_op(input isc_pkg::isc_kind_t k, input logic dep);
    logic got;
    rel = 1'h0;
    fork
      begin
        do_op(k, 64'h240, 2'h3, dep);
        got = rel;
      end
      begin
        repeat (20) @(negedge clock);
        stall = 1'h0;
        rel   = 1'h1;
      end
    join
    check(got, 1'h1, "early");
  endtask : hold_op
  task automatic t_mem;
    do_op(isc_pkg::OP_STORE, 64'h104, 2'h2, 1'h0);
    check(mem_req.be, 8'hF0, "be");
    check({mem_req.valid, mem_req.kind},
          {1'h1, isc_pkg::OP_STORE}, "st");
    check(mem_req.data, 64'h0123_4567_89AB_CDEF, "data");
    do_op(isc_pkg::OP_STORE, 64'h106, 2'h1, 1'h0);
    check(mem_req.be, 8'hC0, "be16");
    do_op(isc_pkg::OP_STORE, 64'h103, 2'h2, 1'h0);
    check({misalign, mem_req.valid}, 2'h2, "mis");
    do_op(isc_pkg::OP_FLUSH, 64'h1234_5677, 2'h0, 1'h0);
    check(mem_req.addr, 64'h1234_5660, "flush");
    $display("t_mem done");
  endtask : t_mem
  task automatic t_sync;
    isc_pkg::isc_kind_t ks[3] = '{isc_pkg::OP_SERIAL, isc_pkg::OP_INTR,
                                  isc_pkg::OP_RFI};
    logic [3:0]         e;
    stall = 1'h1;
    do_op(isc_pkg::OP_FLUSH, 64'h400, 2'h0, 1'h0);
    hold_op(isc_pkg::OP_ISYNC, 1'h0);
    stall = 1'h1;
    do_op(isc_pkg::OP_FLUSH, 64'h440, 2'h0, 1'h0);
    hold_op(isc_pkg::OP_SERIAL, 1'h0);
    foreach (ks[i]) begin
      e = fetch_ctl.epoch;
      do_op(ks[i], 64'h0, 2'h0, 1'h0);
      check(fetch_ctl, {1'h1, e + 4'h1}, "restart");
    end
    $display("t_sync done");
  endtask : t_sync
  task automatic t_order;
    stall = 1'h1;
    do_op(isc_pkg::OP_STORE, 64'h200, 2'h3, 1'h0);
    do_op(isc_pkg::OP_LOAD, 64'h300, 2'h3, 1'h0);
    check({mem_req.valid, mem_req.kind},
          {1'h1, isc_pkg::OP_LOAD}, "ld");
    check(fence_idle, 1'h0, "load held");
    hold_op(isc_pkg::OP_FENCE, 1'h0);
    check(fence_idle, 1'h1, "idle");
    stall = 1'h1;
    do_op(isc_pkg::OP_LOAD, 64'h308, 2'h3, 1'h0);
    hold_op(isc_pkg::OP_STORE, 1'h1);
    $display("t_order done");
  endtask : t_order
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    op     = '0;
    stall  = 1'h0;
    rel    = 1'h0;
    arst_n = 1'h0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    arst_n = 1'h1;
    t_mem;
    t_sync;
    t_order;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    print_verdict;
  end
endmodule : instruction_stream_coherence_bench
`default_nettype wire

// >>> tb/isc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module isc_core_sva #(
  parameter int LINE_SHIFT = isc_pkg::LINE_SHIFT,
  parameter int MAX_OUT    = isc_pkg::MAX_OUT
) (
  input wire logic                  clock,
  input wire logic                  arst_n,
  input wire isc_pkg::isc_op_t      op,
  input wire logic                  op_ready,
  input wire logic                  op_done,
  input wire logic                  misalign,
  input wire isc_pkg::isc_mem_req_t mem_req,
  input wire isc_pkg::isc_mem_ack_t mem_ack,
  input wire isc_pkg::isc_fetch_t   fetch_ctl,
  input wire logic                  fence_idle
);
  isc_pkg::isc_kind_t cur;
  logic               dep;
  logic [3:0]         lcnt;
  logic [3:0]         fcnt;
  wire ld  = mem_req.valid && mem_req.kind == isc_pkg::OP_LOAD;
  wire fl  = mem_req.valid && mem_req.kind == isc_pkg::OP_FLUSH;
  wire ser = cur inside {[isc_pkg::OP_SERIAL:isc_pkg::OP_RFI]};
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur  <= isc_pkg::OP_LOAD;
      dep  <= 1'h0;
      lcnt <= 4'h0;
      fcnt <= 4'h0;
    end else begin
      if (op.valid && op_ready) begin
        cur <= op.kind;
        dep <= op.dep_load;
      end
      lcnt <= lcnt + 4'(ld) - 4'(mem_ack.load_done);
      fcnt <= fcnt + 4'(fl) - 4'(mem_ack.flush_done);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_FLUSH_LINE: assert property (fl |-> mem_req.be == 8'hFF
    && mem_req.addr[LINE_SHIFT-1:0] == '0) else $error("flush addr");
  AST_MISALIGN: assert property (misalign |-> op_done
    && !mem_req.valid) else $error("misalign");
  AST_SER_RESTART: assert property (op_done && ser
    |-> fetch_ctl.restart) else $error("no restart");
  AST_RESTART_SRC: assert property (fetch_ctl.restart
    |-> op_done && ser) else $error("stray restart");
  AST_EPOCH: assert property (fetch_ctl.restart |-> fetch_ctl.epoch
    == $past(fetch_ctl.epoch) + 4'h1) else $error("epoch");
  AST_SYNC_WAIT: assert property (op_done
    && (cur == isc_pkg::OP_ISYNC || ser)
    |-> $past(fcnt) <= 4'($past(mem_ack.flush_done))) else $error("sync");
  AST_FENCE: assert property (op_done && cur == isc_pkg::OP_FENCE
    |-> fence_idle) else $error("fence");
  AST_DEP_LOAD: assert property (mem_req.valid && dep
    |-> $past(lcnt) <= 4'($past(mem_ack.load_done))) else $error("dep");
  cover property (fetch_ctl.restart);
  cover property (misalign);
  cover property (op_done && cur == isc_pkg::OP_FENCE);
endmodule : isc_core_sva
bind isc_core isc_core_sva #(.LINE_SHIFT(LINE_SHIFT), .MAX_OUT(MAX_OUT))
  u_sva (.clock, .arst_n, .op, .op_ready, .op_done, .misalign, .mem_req,
  .mem_ack, .fetch_ctl, .fence_idle);
`default_nettype wire

// >>> tb/isc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module isc_mem_model (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic                  stall,
  input  wire isc_pkg::isc_mem_req_t mem_req,
  output var  logic                  mem_ready,
  output var  isc_pkg::isc_mem_ack_t mem_ack
);
  logic [3:0] pl, ps, pf;
  logic [2:0] t;
  // odd ticks only: slow, and starves only while stall is held
  wire go   = !stall && t[0];
  wire rl   = mem_req.valid && mem_req.kind == isc_pkg::OP_LOAD;
  wire rs   = mem_req.valid && mem_req.kind == isc_pkg::OP_STORE;
  wire rf   = mem_req.valid && mem_req.kind == isc_pkg::OP_FLUSH;
  wire ak_l = go && pl != 4'h0;
  wire ak_s = go && ps != 4'h0;
  wire ak_f = go && pf != 4'h0;
  assign mem_ready = t != 3'h7;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {t, pl, ps, pf} <= '0;
      mem_ack         <= '0;
    end else begin
      t       <= t + 3'h1;
      pl      <= pl + 4'(rl) - 4'(ak_l);
      ps      <= ps + 4'(rs) - 4'(ak_s);
      pf      <= pf + 4'(rf) - 4'(ak_f);
      mem_ack <= '{ak_l, ak_s, ak_f};
    end
  end
endmodule : isc_mem_model
`default_nettype wire

// >>> verilog/isc_core.sv
`timescale 1ns/1ps
`default_nettype none
module isc_core #(
  parameter int LINE_SHIFT = isc_pkg::LINE_SHIFT,
  parameter int MAX_OUT    = isc_pkg::MAX_OUT
) (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire isc_pkg::isc_op_t      op,
  output var  logic                  op_ready,
  output var  logic                  op_done,
  output var  logic                  misalign,
  output var  isc_pkg::isc_mem_req_t mem_req,
  input  wire logic                  mem_ready,
  input  wire isc_pkg::isc_mem_ack_t mem_ack,
  output var  isc_pkg::isc_fetch_t   fetch_ctl,
  output var  logic                  fence_idle
);
  localparam logic [isc_pkg::CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [isc_pkg::CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [isc_pkg::CNT_W-1:0] CNT_LIM  =
    isc_pkg::CNT_W'(MAX_OUT);
  localparam logic [isc_pkg::EPOCH_W-1:0] EP_ONE = 4'h1;
  localparam int                          OFF_W  = $clog2(isc_pkg::BE_W);
  localparam logic [OFF_W-1:0]            AL_SZ1 = 3'h0;
  localparam logic [OFF_W-1:0]            AL_SZ2 = 3'h1;
  localparam logic [OFF_W-1:0]            AL_SZ4 = 3'h3;
  localparam logic [OFF_W-1:0]            AL_SZ8 = 3'h7;

  isc_pkg::isc_state_t s;
  isc_pkg::isc_state_t next_s;

  logic                        aligned;
  logic [isc_pkg::BE_W-1:0]    be_base;
  logic [isc_pkg::BE_W-1:0]    be;
  logic                        dep_ok;
  logic                        mem_go;
  logic                        go;
  logic                        issue;
  logic [isc_pkg::CNT_W-1:0]   tgt_cnt;
  logic [isc_pkg::ADDR_W-1:0]  line_addr;
  logic                        all_idle;
  logic [OFF_W-1:0]            align_mask;
  logic [OFF_W-1:0]            byte_off;
  logic                        drop;
  logic                        ser_kind;
  logic [isc_pkg::CNT_W-1:0]   loads_left;
  logic [isc_pkg::CNT_W-1:0]   stores_left;
  logic [isc_pkg::CNT_W-1:0]   flushes_left;

  always_comb begin
    case (s.pend.size)
      2'h0: begin
        be_base    = isc_pkg::BE_SZ1;
        align_mask = AL_SZ1;
      end
      2'h1: begin
        be_base    = isc_pkg::BE_SZ2;
        align_mask = AL_SZ2;
      end
      2'h2: begin
        be_base    = isc_pkg::BE_SZ4;
        align_mask = AL_SZ4;
      end
      default: begin
        be_base    = isc_pkg::BE_SZ8;
        align_mask = AL_SZ8;
      end
    endcase
  end

  assign byte_off = s.pend.addr[OFF_W-1:0];
  // natural alignment: no offset bit below the access size is set
  assign aligned  = ~|(byte_off & align_mask);
  // misaligned store is dropped, never split into two beats
  assign drop     = (s.pend.kind == isc_pkg::OP_STORE) && !aligned; // RQ1
  // whole store leaves in one beat, never split across requests
  assign be = be_base << byte_off; // RQ1

  // flush is always widened to the whole line, exactly two 16-byte bundles
  assign line_addr = {s.pend.addr[isc_pkg::ADDR_W-1:LINE_SHIFT],
                      {LINE_SHIFT{1'b0}}}; // RQ7

  assign all_idle = (s.loads == CNT_ZERO) && (s.stores == CNT_ZERO) &&
                    (s.flushes == CNT_ZERO);

  // access behind a load-dependent branch waits for load data
  assign dep_ok = !s.pend.dep_load || (s.loads == CNT_ZERO); // RQ8

  assign ser_kind = (s.pend.kind == isc_pkg::OP_SERIAL) ||
                    (s.pend.kind == isc_pkg::OP_INTR) ||
                    (s.pend.kind == isc_pkg::OP_RFI);

  // completions retire outstanding work; issue adds to it later
  assign loads_left   = s.loads - isc_pkg::CNT_W'(mem_ack.load_done);
  assign stores_left  = s.stores - isc_pkg::CNT_W'(mem_ack.store_done);
  assign flushes_left = s.flushes - isc_pkg::CNT_W'(mem_ack.flush_done);

  always_comb begin
    case (s.pend.kind)
      isc_pkg::OP_LOAD:  tgt_cnt = s.loads;
      isc_pkg::OP_STORE: tgt_cnt = s.stores;
      default:           tgt_cnt = s.flushes;
    endcase
  end

  // loads do not look at pending stores: reordering is allowed
  assign mem_go = mem_ready && dep_ok && (tgt_cnt < CNT_LIM); // RQ9

  always_comb begin
    go    = 1'b0;
    issue = 1'b0;
    case (s.pend.kind)
      isc_pkg::OP_LOAD: begin
        go    = mem_go;
        issue = mem_go;
      end
      isc_pkg::OP_STORE: begin
        go    = mem_go || !aligned;
        issue = mem_go && aligned; // RQ1
      end
      isc_pkg::OP_FLUSH: begin
        go    = mem_go; // RQ2
        issue = mem_go;
      end
      isc_pkg::OP_ISYNC: begin
        go = (s.flushes == CNT_ZERO); // RQ4
      end
      isc_pkg::OP_SERIAL,
      isc_pkg::OP_INTR,
      isc_pkg::OP_RFI: begin
        // no isync needed first: waits here until no flush is pending
        go = (s.flushes == CNT_ZERO); // RQ5 RQ6
      end
      isc_pkg::OP_FENCE: begin
        go = all_idle; // RQ10
      end
      default: begin
        go = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_s               = s;
    next_s.mem.valid     = 1'b0;
    next_s.fetch.restart = 1'b0;
    next_s.done          = 1'b0;
    next_s.misalign      = 1'b0;
    next_s.loads   = loads_left;
    next_s.stores  = stores_left;
    next_s.flushes = flushes_left;
    case (s.st)
      isc_pkg::ST_IDLE: begin
        if (op.valid && s.ready) begin
          next_s.pend  = op;
          next_s.ready = 1'b0;
          next_s.st    = isc_pkg::ST_HOLD;
        end
      end
      isc_pkg::ST_HOLD: begin
        // one op held at a time: every wait blocks all later ops
        if (go) begin
          next_s.done  = 1'b1;
          next_s.ready = 1'b1;
          next_s.st    = isc_pkg::ST_IDLE;
          if (drop) begin // RQ1
            next_s.misalign = 1'b1;
          end
          if (issue) begin
            next_s.mem.valid = 1'b1;
            next_s.mem.kind  = s.pend.kind;
            next_s.mem.data  = s.pend.data;
            next_s.mem.be    = be;
            next_s.mem.addr  = s.pend.addr;
            case (s.pend.kind)
              isc_pkg::OP_LOAD: begin
                next_s.loads = next_s.loads + CNT_ONE;
              end
              isc_pkg::OP_STORE: begin
                next_s.stores = next_s.stores + CNT_ONE;
              end
              default: begin
                // no data-side icache snoop; only this flush cleans
                next_s.mem.addr = line_addr; // RQ2 RQ3
                next_s.mem.be   = isc_pkg::BE_SZ8;
                next_s.flushes  = next_s.flushes + CNT_ONE;
              end
            endcase
          end
          if (ser_kind) begin
            // new epoch: fetch drops groups tagged with older epochs
            next_s.fetch.restart = 1'b1; // RQ5 RQ6
            next_s.fetch.epoch   = s.fetch.epoch + EP_ONE;
          end
        end
      end
      default: begin
        next_s.st    = isc_pkg::ST_IDLE;
        next_s.ready = 1'b1;
      end
    endcase
    // counts after this edge, so the status never lags a completion
    next_s.idle = (next_s.loads == CNT_ZERO) &&
                  (next_s.stores == CNT_ZERO) &&
                  (next_s.flushes == CNT_ZERO);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s       <= '0;
      s.ready <= 1'b1;
      s.idle  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign op_ready  = s.ready;
  assign op_done   = s.done;
  assign misalign  = s.misalign;
  assign mem_req   = s.mem;
  assign fetch_ctl = s.fetch;
  assign fence_idle = s.idle;
endmodule : isc_core
`default_nettype wire

// >>> verilog/isc_pkg.sv
// Contract
// RQ1 - aligned store reaches memory as one beat
// RQ2 - line flush made coherent with instruction caches
// RQ3 - no icache snooping of plain data stores
// RQ4 - isync completes only after earlier flushes visible
// RQ5 - serialize waits isync, restarts later fetch groups
// RQ6 - interruption and return each serialize fetch
// RQ7 - flush covers line of two 16-byte bundles
// RQ8 - branch-dependent access waits for earlier load data
// RQ9 - loads may pass stores; only fence stops it
// RQ10 - fence blocks later accesses until all visible
`default_nettype none
package isc_pkg;
  localparam int ADDR_W        = 64;
  localparam int DATA_W        = 64;
  localparam int BE_W          = 8;
  localparam int CNT_W         = 4;
  localparam int EPOCH_W       = 4;
  localparam int BUNDLE_BYTES  = 16;
  localparam int LINE_SHIFT    = 5;
  localparam int MAX_OUT       = 8;
  localparam logic [BE_W-1:0] BE_SZ1 = 8'h01;
  localparam logic [BE_W-1:0] BE_SZ2 = 8'h03;
  localparam logic [BE_W-1:0] BE_SZ4 = 8'h0F;
  localparam logic [BE_W-1:0] BE_SZ8 = 8'hFF;

  typedef enum logic [2:0] {
    OP_LOAD   = 3'h0,
    OP_STORE  = 3'h1,
    OP_FLUSH  = 3'h2,
    OP_ISYNC  = 3'h3,
    OP_SERIAL = 3'h4,
    OP_INTR   = 3'h5,
    OP_RFI    = 3'h6,
    OP_FENCE  = 3'h7
  } isc_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HOLD = 2'h1
  } isc_st_t;

  typedef struct packed {
    logic              valid;
    isc_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0]        size;
    logic              dep_load;
  } isc_op_t;

  typedef struct packed {
    logic              valid;
    isc_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0]   be;
  } isc_mem_req_t;

  typedef struct packed {
    logic load_done;
    logic store_done;
    logic flush_done;
  } isc_mem_ack_t;

  typedef struct packed {
    logic               restart;
    logic [EPOCH_W-1:0] epoch;
  } isc_fetch_t;

  typedef struct packed {
    isc_st_t          st;
    isc_op_t          pend;
    logic [CNT_W-1:0] loads;
    logic [CNT_W-1:0] stores;
    logic [CNT_W-1:0] flushes;
    isc_mem_req_t     mem;
    isc_fetch_t       fetch;
    logic             ready;
    logic             done;
    logic             misalign;
    logic             idle;
  } isc_state_t;
endpackage : isc_pkg
`default_nettype wire
